// >>> bench/diag_record_builder_assertions.sv
// diag_record_builder_assertions.sv: port checks of the record builder
// assumes: bound to diag_record_builder, one clock, async low reset
`timescale 1ns/1ps
`default_nettype none
module diag_record_checker (
  input  wire logic        ref_clk_i,       // system clock
  input  wire logic        rst_n_i,         // async reset, active low
  input  wire logic        diag_enable_i,   // interrupt release
  input  wire logic        handler_done_i,  // handler exit
  input  wire logic        diag_irq_o,      // handler request
  input  wire logic        diag_outgoing_o, // outgoing call
  input  wire logic [31:0] local_dword_o,   // basic record
  input  wire logic        log_valid_o,     // log entry pulse
  input  wire logic [7:0]  log_cause_o      // log entry cause
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  // fixed-zero fields of the basic record
  chk_b0_top_zero: assert property (local_dword_o[7:5] == 3'h0)
    else $error("byte0 top bits set");
  chk_b1_top_zero: assert property (local_dword_o[15:13] == 3'h0)
    else $error("byte1 top bits set");
  chk_b2_fixed_zero: assert property (
    (local_dword_o[23:16] & 8'hef) == 8'h00)
    else $error("byte2 fixed bits set");
  chk_b3_fixed_zero: assert property (
    (local_dword_o[31:24] & 8'hbf) == 8'h00)
    else $error("byte3 fixed bits set");
  // channel info and module failure share the same causes
  chk_chan_info_tie: assert property (
    local_dword_o[12] == local_dword_o[0])
    else $error("channel info differs from module failure");
  chk_int_supply_err: assert property (
    local_dword_o[20] |-> local_dword_o[1])
    else $error("internal supply without internal error");
  chk_outgoing_b3_zero: assert property (
    diag_irq_o && diag_outgoing_o |-> local_dword_o[31:24] == 8'h00)
    else $error("outgoing record byte3 not zero");
  // log entry comes with the handler call and carries byte0
  chk_log_with_call: assert property ($rose(diag_irq_o) |-> log_valid_o)
    else $error("handler call without log entry");
  chk_log_cause_b0: assert property (
    log_valid_o |-> log_cause_o == local_dword_o[7:0] ##1 !log_valid_o)
    else $error("log cause or pulse wrong");
  chk_call_enabled: assert property (
    $rose(diag_irq_o) |-> $past(diag_enable_i, 2))
    else $error("handler call while release off");
  chk_class_code: assert property (
    diag_irq_o |-> local_dword_o[11:8] inside {4'hf, 4'h8})
    else $error("bad module class");
  chk_exit_drops: assert property (
    diag_irq_o && handler_done_i |=> !diag_irq_o)
    else $error("handler request stays after exit");
endmodule
`default_nettype wire

// >>> bench/module_diagnostic_record_builder_tb_top.sv
// tb top: drives fault causes, checks record, log entry and read port
// assumes: package, header and design compiled before this file
`timescale 1ns/1ps
`default_nettype none
`include "diag_record_regs.svh"
module module_diagnostic_record_builder_tb_top;
  logic        ref_clk_i = 1'b0;          // 20 mhz clock
  logic        rst_n_i = 1'b0;            // async reset
  logic        diag_enable_i = 1'b1;      // interrupt release
  logic        function_module_i = 1'b0;  // module class select
  logic [1:0]  mode_i = 2'h0;             // operating mode
  logic [15:0] module_addr_i = 16'h0123;  // module address
  logic [95:0] ext_data_i = 96'h0f0e0d0c0b0a090807060504;
  logic        handler_done_i = 1'b0;     // handler exit
  logic [3:0]  rd_addr_i = 4'h0;          // read index
  logic [5:0]  f = 6'h00;                 // fault causes
  wire  logic  irq_lost_i = f[0], supply_miss_i = f[1], short_ovl_i = f[2];
  wire  logic  external_err_i = f[3], channel_err_i = f[4];
  wire  logic  ext_supply_miss_i = f[5];
  logic [7:0]  rd_data_o, log_cause_o;
  logic        diag_irq_o, diag_outgoing_o, log_valid_o;
  logic [31:0] local_dword_o;
  logic [15:0] log_addr_o;
  int          mismatches = 0, n_compared = 0;

  diag_record_builder diag_record_builder_i (
    .ref_clk_i         (ref_clk_i),
    .rst_n_i           (rst_n_i),
    .diag_enable_i     (diag_enable_i),
    .function_module_i (function_module_i),
    .mode_i            (mode_i),
    .module_addr_i     (module_addr_i),
    .irq_lost_i        (irq_lost_i),
    .supply_miss_i     (supply_miss_i),
    .short_ovl_i       (short_ovl_i),
    .external_err_i    (external_err_i),
    .channel_err_i     (channel_err_i),
    .ext_supply_miss_i (ext_supply_miss_i),
    .ext_data_i        (ext_data_i),
    .handler_done_i    (handler_done_i),
    .rd_addr_i         (rd_addr_i),
    .rd_data_o         (rd_data_o),
    .diag_irq_o        (diag_irq_o),
    .diag_outgoing_o   (diag_outgoing_o),
    .local_dword_o     (local_dword_o),
    .log_valid_o       (log_valid_o),
    .log_cause_o       (log_cause_o),
    .log_addr_o        (log_addr_o)
  );

  // clock generator
  initial begin
    forever #25 ref_clk_i = ~ref_clk_i;
  end

  // compare and count
  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    n_compared++;
    if (g !== e) begin
      mismatches++;
      $display("Error %0t: got %h expected %h", $time, g, e);
    end
  endtask

  // verdict and end of run
  task automatic tally_and_finish;
    if (mismatches == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask

  // bounded wait for the log entry pulse
  task automatic wait_log;
    for (int k = 0; k < 10; k++) begin
      @(posedge ref_clk_i);
      #1;
      if (log_valid_o === 1'b1) return;
    end
    mismatches++;
    $display("Error %0t: no handler call", $time);
    tally_and_finish();
  endtask

  // read one record byte through the read port
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge ref_clk_i);
    rd_addr_i <= a;
    repeat (2) @(posedge ref_clk_i);
    #1 cmp(32'(rd_data_o), 32'(e));
  endtask

  // leave the handler, request must drop
  task automatic done;
    @(posedge ref_clk_i);
    handler_done_i <= 1'b1;
    @(posedge ref_clk_i);
    handler_done_i <= 1'b0;
    #1 cmp(32'(diag_irq_o), 32'h0);
  endtask

  // expected incoming record {b3,b2,b1,b0}
  function automatic logic [31:0] rec(input logic [5:0] c, input logic fm);
    logic l;
    l = c[0] | c[1] | c[2];
    return {1'b0, c[0], 6'h00, 3'h0, c[1], 4'h0, 3'h0, l,
            fm ? `DIAG_CLASS_FUNCTION : `DIAG_CLASS_DIGITAL,
            3'h0, c[5], c[4], c[3], c[1] | c[2], l};
  endfunction

  // main sequence
  initial begin
    logic [5:0]  c;
    logic [31:0] e;
    repeat (10) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    // each cause alone, then all together, across classes and modes
    for (int i = 0; i < 7; i++) begin
      c = (i < 6) ? 6'(1 << i) : 6'h3f;
      e = rec(c, i[0]);
      @(posedge ref_clk_i);
      function_module_i <= i[0];
      mode_i <= i[1:0];
      f <= c;
      wait_log();
      cmp(local_dword_o, e);
      cmp(32'(log_cause_o), 32'(e[7:0]));
      cmp(32'(log_addr_o), 32'h0123);
      cmp(32'(diag_outgoing_o), 32'h0);
      rd(4'h3, e[31:24]);
      rd(4'h4, 8'h04);
      rd(4'hf, 8'h0f);
      done();
      @(posedge ref_clk_i);
      f <= 6'h00;
      wait_log();
      cmp(32'(diag_outgoing_o), 32'h1);
      cmp(32'(local_dword_o[31:24]), 32'h0);
      // outgoing record: flags all clear, only the class code stays
      e = {20'h00000, e[11:8], 8'h00};
      cmp(local_dword_o, e);
      done();
    end
    // release off: no call, latest event still readable
    @(posedge ref_clk_i);
    diag_enable_i <= 1'b0;
    f <= 6'h02;
    repeat (6) @(posedge ref_clk_i);
    #1 cmp(32'(diag_irq_o), 32'h0);
    rd(4'h0, 8'h03);
    rd(4'h2, 8'h10);
    @(posedge ref_clk_i);
    f <= 6'h00;
    repeat (6) @(posedge ref_clk_i);
    #1 cmp(32'(diag_irq_o), 32'h0);
    rd(4'h0, 8'h00);
    tally_and_finish();
  end
endmodule

bind diag_record_builder diag_record_checker diag_record_checker_i (
  .ref_clk_i       (ref_clk_i),
  .rst_n_i         (rst_n_i),
  .diag_enable_i   (diag_enable_i),
  .handler_done_i  (handler_done_i),
  .diag_irq_o      (diag_irq_o),
  .diag_outgoing_o (diag_outgoing_o),
  .local_dword_o   (local_dword_o),
  .log_valid_o     (log_valid_o),
  .log_cause_o     (log_cause_o)
);
`default_nettype wire

// >>> hdl/diag_byte_latch.sv
// diag_byte_latch.sv: one snapshot byte of the diagnostic record
// assumes: single clock, async active-low reset, load is a pulse
`timescale 1ns/1ps
`default_nettype none
`include "diag_record_regs.svh"

module diag_byte_latch #(
  parameter int WIDTH = 8
) (
  input  wire logic             ref_clk_i,  // system clock
  input  wire logic             rst_n_i,    // async reset, active low
  input  wire logic             load_i,     // capture strobe
  input  wire logic [WIDTH-1:0] d_i,        // value to capture
  output logic      [WIDTH-1:0] q_o         // held value
);

  // hold the byte until the next capture
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      q_o <= WIDTH'(`DIAG_BYTE_RESET);
    end else if (load_i) begin
      q_o <= d_i;
    end
  end

endmodule
`default_nettype wire

// >>> hdl/diag_record_builder.sv
// diag_record_builder.sv: builds and holds the diagnostic record
// assumes: fault inputs are synchronous levels; software reads bytes
// through a byte-wide read port and acknowledges handler exit
//
// What this block does
// - every handler call logs cause and module address
// - basic record ready when handler entered
// - interrupt disabled still keeps latest event
// - byte0 bit0 module failure from listed causes
// - byte0 bit1 internal error on supply, short
// - byte0 bit2 external error, bits 7:5 zero
// - byte0 bit3 flags channel error
// - byte0 bit4 flags missing external supply
// - byte1 low nibble holds module class code
// - byte1 bit4 channel info, bits 7:5 zero
// - byte2 bit4 missing internal supply only
// - incoming byte3 bit6 lost process interrupt
// - outgoing message if still enabled, byte3 zero
// - same basic layout in every mode
// - extended record readable through read service
// - extended record is basic plus twelve bytes
`timescale 1ns/1ps
`default_nettype none
`include "diag_record_regs.svh"

module diag_record_builder
  import diag_record_pkg::*;
#(
  parameter int ADDR_W = 16,  // module address width
  parameter int EXT_W  = 96   // module-specific extended data bits
) (
  input  wire logic              ref_clk_i,         // 20 mhz clock
  input  wire logic              rst_n_i,           // async reset
  input  wire logic              diag_enable_i,     // interrupt release
  input  wire logic              function_module_i, // 1: counter/freq
  input  wire logic [1:0]        mode_i,            // operating mode
  input  wire logic [ADDR_W-1:0] module_addr_i,     // base address
  input  wire logic              irq_lost_i,        // process irq lost
  input  wire logic              supply_miss_i,     // di/do supply gone
  input  wire logic              short_ovl_i,       // output short
  input  wire logic              external_err_i,    // external error
  input  wire logic              channel_err_i,     // channel error
  input  wire logic              ext_supply_miss_i, // external supply
  input  wire logic [EXT_W-1:0]  ext_data_i,        // bytes 4..15
  input  wire logic              handler_done_i,    // handler exit
  input  wire logic [3:0]        rd_addr_i,         // record byte index
  output logic      [7:0]        rd_data_o,         // record byte
  output logic                   diag_irq_o,        // handler request
  output logic                   diag_outgoing_o,   // 1: outgoing call
  output logic      [31:0]       local_dword_o,     // basic record
  output logic                   log_valid_o,       // buffer entry pulse
  output logic      [7:0]        log_cause_o,       // entry cause
  output logic      [ADDR_W-1:0] log_addr_o         // entry address
);

  // any fault condition present
  logic              fault_any;
  // next byte values built from the live fault inputs
  logic [7:0]        b0_d;
  logic [7:0]        b1_d;
  logic [7:0]        b2_d;
  logic [7:0]        b3_d;
  // snapshot strobe and held bytes
  logic              capture;
  logic [7:0]        b0_q;
  logic [7:0]        b1_q;
  logic [7:0]        b2_q;
  logic [7:0]        b3_q;
  logic [EXT_W-1:0]  ext_q;      // held extended data
  // sequencing
  diag_state_e       state_q;
  diag_state_e       state_d;
  logic              fault_q;    // fault seen at last snapshot
  logic              evt_in;     // incoming event this cycle
  logic              evt_out;    // outgoing event this cycle
  logic              outgoing_d; // kind of event being captured
  // unused mode input, layout is the same for all modes
  diag_mode_e        mode;

  assign mode = diag_mode_e'(mode_i);

  assign fault_any = irq_lost_i | supply_miss_i | short_ovl_i |
                     external_err_i | channel_err_i | ext_supply_miss_i;

  // byte 0: fault class flags
  always_comb begin
    b0_d = 8'h00;
    b0_d[`DIAG_B0_MODULE_FAIL]  = irq_lost_i | supply_miss_i |
                                  short_ovl_i;
    b0_d[`DIAG_B0_INTERNAL_ERR] = supply_miss_i | short_ovl_i;
    b0_d[`DIAG_B0_EXTERNAL_ERR] = external_err_i;
    b0_d[`DIAG_B0_CHANNEL_ERR]  = channel_err_i;
    b0_d[`DIAG_B0_EXT_SUPPLY]   = ext_supply_miss_i;
  end

  // byte 1: module class and channel information flag
  always_comb begin
    b1_d = 8'h00;
    b1_d[3:0] = function_module_i ? `DIAG_CLASS_FUNCTION
                                  : `DIAG_CLASS_DIGITAL;
    b1_d[`DIAG_B1_CHAN_INFO] = irq_lost_i | supply_miss_i |
                               short_ovl_i;
  end

  // byte 2: internal supply flag only
  always_comb begin
    b2_d = 8'h00;
    b2_d[`DIAG_B2_INT_SUPPLY] = supply_miss_i;
  end

  // byte 3: lost process interrupt, zero in the outgoing record
  always_comb begin
    b3_d = 8'h00;
    if (!outgoing_d) begin
      b3_d[`DIAG_B3_LOST_IRQ] = irq_lost_i;
    end
  end

  // event detection: a fault appears or the last fault clears; only
  // while idle, so a change in the wait cycle cannot split the record
  assign evt_in  = fault_any & ~fault_q & (state_q == ST_IDLE);
  assign evt_out = ~fault_any & fault_q & (state_q == ST_IDLE);
  assign outgoing_d = evt_out;
  // capture on every event even with the interrupt released off
  assign capture = evt_in | evt_out;

  // all bytes load on the same strobe so they describe one event
  diag_byte_latch #(.WIDTH(8)) u_b0 (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .load_i    (capture),
    .d_i       (b0_d),
    .q_o       (b0_q)
  );
  diag_byte_latch #(.WIDTH(8)) u_b1 (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .load_i    (capture),
    .d_i       (b1_d),
    .q_o       (b1_q)
  );
  diag_byte_latch #(.WIDTH(8)) u_b2 (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .load_i    (capture),
    .d_i       (b2_d),
    .q_o       (b2_q)
  );
  diag_byte_latch #(.WIDTH(8)) u_b3 (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .load_i    (capture),
    .d_i       (b3_d),
    .q_o       (b3_q)
  );
  diag_byte_latch #(.WIDTH(EXT_W)) u_ext (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .load_i    (capture),
    .d_i       (ext_data_i),
    .q_o       (ext_q)
  );

  // remember fault level at each snapshot
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      fault_q <= 1'b0;
    end else if (capture) begin
      fault_q <= evt_in;
    end
  end

  // next state: a released event enters the handler
  always_comb begin
    state_d = state_q;
    case (state_q)
      ST_IDLE: begin
        if (capture && diag_enable_i) begin
          state_d = ST_WAIT;
        end
      end
      ST_WAIT: begin
        state_d = ST_ACTIVE; // record stable, raise request
      end
      ST_ACTIVE: begin
        if (handler_done_i) begin
          state_d = ST_IDLE;
        end
      end
      default: begin
        state_d = ST_IDLE;
      end
    endcase
  end

  // state register
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state_q <= ST_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  // handler request rises with the record, one cycle after the snapshot
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      diag_irq_o      <= 1'b0;
      diag_outgoing_o <= 1'b0;
      local_dword_o   <= 32'h0000_0000;
    end else begin
      diag_irq_o <= (state_d == ST_ACTIVE);
      if (state_q == ST_WAIT) begin
        local_dword_o   <= {b3_q, b2_q, b1_q, b0_q};
        diag_outgoing_o <= ~fault_q;
      end
    end
  end

  // diagnostic buffer entry on each handler call
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      log_valid_o <= 1'b0;
      log_cause_o <= 8'h00;
      log_addr_o  <= '0;
    end else begin
      log_valid_o <= (state_q == ST_WAIT);
      if (state_q == ST_WAIT) begin
        log_cause_o <= b0_q;
        log_addr_o  <= module_addr_i;
      end
    end
  end

  // read port: bytes 0..3 basic, 4..15 extended data
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_data_o <= 8'h00;
    end else begin
      case (rd_addr_i)
        `DIAG_OFS_FAULT_CLASS:  rd_data_o <= b0_q;
        `DIAG_OFS_MODULE_CLASS: rd_data_o <= b1_q;
        `DIAG_OFS_INT_SUPPLY:   rd_data_o <= b2_q;
        `DIAG_OFS_LOST_IRQ:     rd_data_o <= b3_q;
        default: begin
          rd_data_o <= ext_q[(32'(rd_addr_i) - 4) * 8 +: 8];
        end
      endcase
    end
  end

endmodule
`default_nettype wire

// >>> include/diag_record_pkg.sv
// diag_record_pkg.sv: types shared by the diagnostic record builder
// assumes: nothing beyond a SystemVerilog compiler
package diag_record_pkg;

  // sequencing states of the record builder, one-hot
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b001,
    ST_ACTIVE = 3'b010,
    ST_WAIT   = 3'b100
  } diag_state_e;

  // operating modes; the basic record is identical in all of them
  typedef enum logic [1:0] {
    MODE_ALARM = 2'h0,
    MODE_COUNT = 2'h1,
    MODE_FREQ  = 2'h2,
    MODE_PWM   = 2'h3
  } diag_mode_e;

endpackage

// >>> include/diag_record_regs.svh
// diag_record_regs.svh: offsets, bit positions and codes of the record
// assumes: included by bare name from design and bench files
`ifndef DIAG_RECORD_REGS_SVH
`define DIAG_RECORD_REGS_SVH

// byte offsets of the basic record
`define DIAG_OFS_FAULT_CLASS     4'h0
`define DIAG_OFS_MODULE_CLASS    4'h1
`define DIAG_OFS_INT_SUPPLY      4'h2
`define DIAG_OFS_LOST_IRQ        4'h3
// extended record length in bytes
`define DIAG_EXT_LEN             5'h10
// byte 0 field positions
`define DIAG_B0_MODULE_FAIL      0
`define DIAG_B0_INTERNAL_ERR     1
`define DIAG_B0_EXTERNAL_ERR     2
`define DIAG_B0_CHANNEL_ERR      3
`define DIAG_B0_EXT_SUPPLY       4
// byte 1 field positions
`define DIAG_B1_CHAN_INFO        4
// byte 2 field position
`define DIAG_B2_INT_SUPPLY       4
// byte 3 field position
`define DIAG_B3_LOST_IRQ         6
// module class codes
`define DIAG_CLASS_DIGITAL       4'hf
`define DIAG_CLASS_FUNCTION      4'h8
// reset value of every record byte
`define DIAG_BYTE_RESET          8'h00

`endif
